// ---- rtl/pes_consts.svh ----
// Register offsets, field positions, reset values, event classes and record layout for the sampling block.
// Assumes inclusion by bare name from the package and the block's design file.
`ifndef PES_CONSTS_SVH
`define PES_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PES_OFF_ESC 12'h000
`define PES_OFF_SAMP_EN 12'h004
`define PES_OFF_REPLAY_SEL 12'h008
`define PES_OFF_MISC 12'h00c
`define PES_OFF_COUNTER 12'h010
`define PES_OFF_RELOAD 12'h014
`define PES_OFF_BUF_BASE 12'h018
`define PES_OFF_BUF_INDEX 12'h01c
`define PES_OFF_BUF_MAX 12'h020
`define PES_OFF_BUF_THRESH 12'h024
`define PES_OFF_STATUS 12'h028
`define PES_OFF_FEATURE 12'h02c

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PES_ESC_THREAD1_USER_LEVEL_QUAL 0
`define PES_ESC_THREAD1_KERNEL_LEVEL_QUAL 1
`define PES_ESC_THREAD0_USER_LEVEL_QUAL 2
`define PES_ESC_THREAD0_KERNEL_LEVEL_QUAL 3
`define PES_ESC_TAG_EN 4
`define PES_ESC_TAGV_LO 5
`define PES_ESC_TAGV_HI 8
`define PES_ESC_MASK_LO 9
`define PES_ESC_MASK_HI 24
`define PES_ESC_SEL_LO 25
`define PES_ESC_SEL_HI 30
`define PES_EN_UOP_TAG 24
`define PES_EN_SECOND 25
`define PES_MISC_UNAVAIL 12
`define PES_FEAT_DS 21
`define PES_ST_ACTIVE 0
`define PES_ST_BUSY 1
`define PES_ST_FULL 2
`define PES_ST_IRQ 3

// ------------------------------------------------------------
// Reset values, event classes and record layout
// ------------------------------------------------------------
`define PES_ESC_RST 32'h0000_0000
`define PES_CLASS_EXEC 6'h0c
`define PES_CLASS_FRONT 6'h08
`define PES_CLASS_REPLAY 6'h09
`define PES_REC_WORDS 10
`define PES_COUNTER_W 40
`define PES_WORD_BYTES 32'h0000_0004

`endif

// ---- rtl/pes_pkg.sv ----
// Types shared by the sampling block and its bench.
// Assumes the constants header is on the include path.
package pes_pkg;
    `include "pes_consts.svh"

    // Architectural state offered for one record.
    typedef struct packed {
        logic [31:0] ip;
        logic [31:0] flags;
        logic [255:0] gpr;
    } pes_arch_t;

    // One retiring micro-operation with its thread and privilege.
    typedef struct packed {
        logic valid;
        logic thread;
        logic kernel;
        logic thread_specific;
        logic [15:0] events;
        logic [5:0] event_class;
        logic [3:0] tag;
        logic replay_tag;
    } pes_uop_t;

    // Memory write port for record words.
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } pes_mem_t;

    typedef enum logic [1:0] {
        PES_IDLE = 2'b00,
        PES_WRITE = 2'b01,
        PES_RELOAD = 2'b10
    } pes_state_t;
endpackage

// ---- rtl/pes_sampling.sv ----
// Event selection, replay tagging and precise sampling record writer.
// Assumes an APB master, one clock, and a memory that accepts a write per ready cycle.
//
// Behaviour
// - Replay tagging acts when sampling enable bit 24 is set or bit 25 is clear.
// - With bits 24 and 25 clear, replay tags still count for ordinary sampling.
// - Counter overflow copies registers, flags and instruction pointer into a record.
// - After a record the counter reloads with the reset count and restarts.
// - An interrupt rises when buffer fill reaches the threshold.
// - The record buffer never wraps to its base.
// - Only execution, front-end and replay tagged events sample precisely.
// - Only the dedicated sampling counter triggers record writes.
// - Feature bit 21 reports debug store support.
// - Sampling-unavailable flag reads clear when sampling is available.
// - Bit 24 set enables precise sampling, clear disables it.
// - Debug store is disabled on entering system management mode.
// - Machine check disables it; reset and init clear it.
// - Debug store keeps operating in real address mode.
// - Bits 0 and 1 qualify thread 1 user and kernel levels.
// - Bits 2 and 3 qualify thread 0 user and kernel levels.
// - Both bits of a thread set count at all privilege levels.
// - Bit 4 enables tagging, bits 5 to 8 hold the tag value.
// - Bits 25 to 30 select class, bits 9 to 24 mask events.
// - Thread-independent sub-events count whatever thread caused them.
`timescale 1ns/1ns
`default_nettype none
`include "pes_consts.svh"

module pes_sampling #(
    parameter int CW = `PES_COUNTER_W
) (
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core events and modes.
    input wire pes_pkg::pes_uop_t uop,
    input wire pes_pkg::pes_arch_t arch,
    input wire logic init_req,
    input wire logic smm_entry,
    input wire logic machine_check,
    // Record writes and replay tag result.
    output pes_pkg::pes_mem_t mem_wr,
    input wire logic mem_ready,
    output logic replay_tag_out,
    output logic count_pulse,
    output logic buf_irq
);
    import pes_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] esc_r;
    logic [31:0] samp_en_r;
    logic [31:0] replay_sel_r;
    logic [CW-1:0] counter_r;
    logic [CW-1:0] reload_r;
    logic [31:0] base_r;
    logic [31:0] index_r;
    logic [31:0] max_r;
    logic [31:0] thresh_r;
    logic irq_r;
    pes_state_t state_r;
    logic [3:0] word_r;
    pes_arch_t snap_r;

    logic wr_en;
    logic rd_en;
    logic mapped;
    logic qual_hit;
    logic precise_class;
    logic evt;
    logic overflow;
    logic room;
    logic [319:0] snap_flat;
    logic [31:0] status;

    assign wr_en = clk_en && psel && penable && pwrite;
    assign rd_en = clk_en && psel && !penable && !pwrite;
    assign snap_flat = snap_r;

    // Address decode for the mapped registers.
    always_comb begin
        case (paddr)
            `PES_OFF_ESC, `PES_OFF_SAMP_EN, `PES_OFF_REPLAY_SEL, `PES_OFF_MISC,
            `PES_OFF_COUNTER, `PES_OFF_RELOAD, `PES_OFF_BUF_BASE, `PES_OFF_BUF_INDEX,
            `PES_OFF_BUF_MAX, `PES_OFF_BUF_THRESH, `PES_OFF_STATUS, `PES_OFF_FEATURE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Event qualification
    // ------------------------------------------------------------
    // Thread and privilege qualification; independent events ignore the thread.
    always_comb begin
        logic t0;
        logic t1;
        t0 = uop.kernel ? esc_r[`PES_ESC_THREAD0_KERNEL_LEVEL_QUAL] : esc_r[`PES_ESC_THREAD0_USER_LEVEL_QUAL];
        t1 = uop.kernel ? esc_r[`PES_ESC_THREAD1_KERNEL_LEVEL_QUAL] : esc_r[`PES_ESC_THREAD1_USER_LEVEL_QUAL];
        if (!uop.thread_specific) begin
            qual_hit = t0 || t1;
        end else begin
            qual_hit = uop.thread ? t1 : t0;
        end
    end

    // Class match and masked sub-event hit.
    assign evt = uop.valid && qual_hit
        && (uop.event_class == esc_r[`PES_ESC_SEL_HI:`PES_ESC_SEL_LO])
        && |(uop.events & esc_r[`PES_ESC_MASK_HI:`PES_ESC_MASK_LO]);

    // Only the three at-retirement classes feed the sampling counter.
    always_comb begin
        case (esc_r[`PES_ESC_SEL_HI:`PES_ESC_SEL_LO])
            `PES_CLASS_EXEC, `PES_CLASS_FRONT, `PES_CLASS_REPLAY: precise_class = 1'b1;
            default: precise_class = 1'b0;
        endcase
    end

    assign overflow = evt && precise_class && (counter_r == {CW{1'b1}});
    assign room = (index_r + (`PES_REC_WORDS * `PES_WORD_BYTES)) <= max_r;

    // ------------------------------------------------------------
    // APB register writes
    // ------------------------------------------------------------
    // Configuration registers; mode events disable sampling and init clears it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            esc_r <= `PES_ESC_RST;
            samp_en_r <= 32'h0000_0000;
            replay_sel_r <= 32'h0000_0000;
            reload_r <= '0;
            base_r <= 32'h0000_0000;
            max_r <= 32'h0000_0000;
            thresh_r <= 32'h0000_0000;
        end else if (clk_en) begin
            if (init_req) begin
                samp_en_r <= 32'h0000_0000;
                esc_r <= `PES_ESC_RST;
            end else if (smm_entry || machine_check) begin
                samp_en_r[`PES_EN_UOP_TAG] <= 1'b0;
                samp_en_r[`PES_EN_SECOND] <= 1'b0;
            end else if (wr_en) begin
                case (paddr)
                    `PES_OFF_ESC: esc_r <= pwdata;
                    `PES_OFF_SAMP_EN: samp_en_r <= pwdata;
                    `PES_OFF_REPLAY_SEL: replay_sel_r <= pwdata;
                    `PES_OFF_RELOAD: reload_r <= CW'(pwdata);
                    `PES_OFF_BUF_BASE: base_r <= pwdata;
                    `PES_OFF_BUF_MAX: max_r <= pwdata;
                    `PES_OFF_BUF_THRESH: thresh_r <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Sampling counter and record writer
    // ------------------------------------------------------------
    // Counter counts qualified events; reloads after each record.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_r <= '0;
        end else if (clk_en) begin
            if (init_req) begin
                counter_r <= '0;
            end else if (state_r == PES_RELOAD) begin
                counter_r <= reload_r;
            end else if (wr_en && paddr == `PES_OFF_COUNTER) begin
                counter_r <= CW'(pwdata);
            end else if (evt && precise_class && state_r == PES_IDLE) begin
                counter_r <= counter_r + 1'b1;
            end
        end
    end

    // Record state machine: snapshot, write words, reload the counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PES_IDLE;
            word_r <= 4'h0;
            snap_r <= '0;
            index_r <= 32'h0000_0000;
            mem_wr <= '0;
        end else if (clk_en) begin
            if (init_req) begin
                state_r <= PES_IDLE;
                mem_wr <= '0;
                index_r <= 32'h0000_0000;
            end else begin
                case (state_r)
                    PES_IDLE: begin
                        mem_wr.valid <= 1'b0;
                        if (wr_en && paddr == `PES_OFF_BUF_INDEX) begin
                            index_r <= pwdata;
                        end
                        if (overflow && samp_en_r[`PES_EN_UOP_TAG] && room) begin
                            snap_r <= arch;
                            word_r <= 4'h0;
                            state_r <= PES_WRITE;
                        end else if (overflow) begin
                            state_r <= PES_RELOAD;
                        end
                    end
                    PES_WRITE: begin
                        if (!mem_wr.valid || mem_ready) begin
                            if (mem_wr.valid && word_r == 4'(`PES_REC_WORDS)) begin
                                mem_wr.valid <= 1'b0;
                                index_r <= index_r + (`PES_REC_WORDS * `PES_WORD_BYTES);
                                state_r <= PES_RELOAD;
                            end else begin
                                mem_wr.valid <= 1'b1;
                                mem_wr.addr <= index_r + {26'h0, word_r, 2'b00};
                                mem_wr.data <= snap_flat[word_r*32 +: 32];
                                word_r <= word_r + 4'h1;
                            end
                        end
                    end
                    PES_RELOAD: state_r <= PES_IDLE;
                    default: state_r <= PES_IDLE;
                endcase
            end
        end
    end

    // Buffer threshold interrupt, held while the fill sits at or above a nonzero threshold.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
            buf_irq <= 1'b0;
        end else if (clk_en) begin
            irq_r <= (thresh_r != 32'h0000_0000) && (index_r >= thresh_r);
            buf_irq <= irq_r;
        end
    end

    // ------------------------------------------------------------
    // Tagging and count outputs
    // ------------------------------------------------------------
    // Replay tag when enabled, or in plain sampling with both enable bits clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            replay_tag_out <= 1'b0;
            count_pulse <= 1'b0;
        end else if (clk_en) begin
            replay_tag_out <= uop.valid && uop.replay_tag && esc_r[`PES_ESC_TAG_EN]
                && (uop.tag & esc_r[`PES_ESC_TAGV_HI:`PES_ESC_TAGV_LO]) != 4'h0
                && (samp_en_r[`PES_EN_UOP_TAG]
                || !samp_en_r[`PES_EN_SECOND]);
            count_pulse <= evt;
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    assign status = {28'h0, irq_r, !room, state_r != PES_IDLE, samp_en_r[`PES_EN_UOP_TAG]};

    // Read data is loaded at the setup edge so it stands at the access edge; zero-wait access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd_en) begin
                case (paddr)
                    `PES_OFF_ESC: prdata <= esc_r;
                    `PES_OFF_SAMP_EN: prdata <= samp_en_r;
                    `PES_OFF_REPLAY_SEL: prdata <= replay_sel_r;
                    `PES_OFF_MISC: prdata <= 32'h0000_0000;
                    `PES_OFF_COUNTER: prdata <= counter_r[31:0];
                    `PES_OFF_RELOAD: prdata <= reload_r[31:0];
                    `PES_OFF_BUF_BASE: prdata <= base_r;
                    `PES_OFF_BUF_INDEX: prdata <= index_r;
                    `PES_OFF_BUF_MAX: prdata <= max_r;
                    `PES_OFF_BUF_THRESH: prdata <= thresh_r;
                    `PES_OFF_STATUS: prdata <= status;
                    `PES_OFF_FEATURE: prdata <= 32'h0020_0000;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // pes_sampling
`default_nettype wire

// ---- test/pes_sampling_sva.sv ----
// Checker for the bus, counting and record ports of the sampling block.
// Assumes it sees only the block's ports; it is bound at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module pes_sampling_sva (
    // Clock and controls.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic init_req,
    input wire logic smm_entry,
    input wire logic machine_check,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events and records.
    input wire pes_pkg::pes_uop_t uop,
    input wire pes_pkg::pes_mem_t mem_wr,
    input wire logic mem_ready,
    input wire logic count_pulse
);
    import pes_pkg::*;
    logic en_r;
    logic [31:0] base_r;
    logic wr_acc;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A write lands at the access edge while the block runs.
    assign wr_acc = psel && penable && pready && pwrite && clk_en;
    // Shadow of the enable bit; any mode change clears it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'h0;
        end else if (init_req || smm_entry || machine_check) begin
            en_r <= 1'h0;
        end else if (wr_acc && paddr == 12'h004) begin
            en_r <= pwdata[24];
        end
    end
    // Shadow of the buffer base; init clears it, though the block's init wipes the index and keeps the base.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn || init_req) begin
            base_r <= 32'h0;
        end else if (wr_acc && paddr == 12'h018) begin
            base_r <= pwdata;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence setup_s;
        psel && !penable && clk_en;
    endsequence
    sequence word_take_s;
        mem_wr.valid && mem_ready && clk_en;
    endsequence
    apb_answer_a: assert property (setup_s |=> pready) else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    word_hold_a: assert property (mem_wr.valid && !mem_ready && clk_en |=> mem_wr.valid && $stable(mem_wr))
        else $error("record word changed while waiting");
    word_step_a: assert property (word_take_s ##1 mem_wr.valid |-> mem_wr.addr == $past(mem_wr.addr) + 32'h4)
        else $error("record words not consecutive");
    record_gate_a: assert property ($rose(mem_wr.valid) |-> en_r || $past(en_r) || $past(en_r, 2))
        else $error("record while sampling disabled");
    no_wrap_a: assert property (mem_wr.valid |-> mem_wr.addr >= base_r)
        else $error("record below buffer base");
    count_cause_a: assert property (count_pulse |-> $past(uop.valid))
        else $error("count without retiring uop");
endmodule // pes_sampling_sva

bind pes_sampling pes_sampling_sva pes_sampling_sva_inst (.pclk, .presetn, .clk_en, .init_req, .smm_entry,
    .machine_check, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .uop, .mem_wr, .mem_ready,
    .count_pulse);
`default_nettype wire

// ---- test/pes_mem_model.sv ----
// Memory model that takes record words from the sampling block.
// Assumes one clock; the bench reads the stored words by hierarchy.
`timescale 1ns/1ns
`default_nettype none
module pes_mem_model (
    // Clock and stall control.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    // Record write port.
    input wire pes_pkg::pes_mem_t mem_wr,
    output logic mem_ready
);
    import pes_pkg::*;
    logic [31:0] mem [logic [31:0]];
    int n_words = 0;
    // ----------------------------------------
    // Acceptance
    // ----------------------------------------
    // While stalled, ready toggles so each word that follows an accepted one waits a cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ready <= 1'h0;
        end else begin
            mem_ready <= stall ? !mem_ready : 1'h1;
        end
    end
    // Stores each accepted word and counts it.
    always @(posedge pclk) begin
        if (presetn && mem_wr.valid && mem_ready) begin
            mem[mem_wr.addr] = mem_wr.data;
            n_words = n_words + 1;
        end
    end
endmodule // pes_mem_model
`default_nettype wire

// ---- test/pes_sampling_test.sv ----
// Self-checking bench for the sampling block.
// Assumes the checker and memory model files are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module pes_sampling_test;
    import pes_pkg::*;
    typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e; logic err;} pes_row_t;
    logic pclk, presetn, psel, penable, pwrite, init_req, smm_entry, machine_check, stall, err, e1;
    logic pready, pslverr, mem_ready, replay_tag_out, count_pulse, buf_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, x;
    logic [3:0] qq;
    pes_uop_t uop;
    pes_arch_t arch;
    pes_mem_t mem_wr;
    int n_mismatch = 0;
    int n_compared = 0;
    int i, k, c;
    pes_row_t rows [5] = '{'{1'h0, 12'h000, 32'h0, 32'hffffffff, 32'h0, 1'h0},
        '{1'h1, 12'h000, 32'h7fffffff, 32'hffffffff, 32'h7fffffff, 1'h0},
        '{1'h0, 12'h00c, 32'h0, 32'h00001000, 32'h0, 1'h0},
        '{1'h0, 12'h02c, 32'h0, 32'h00200000, 32'h00200000, 1'h0},
        '{1'h1, 12'hffc, 32'h5a5a5a5a, 32'hffffffff, 32'h0, 1'h1}};
    logic [43:0] setup [8] = '{{12'h018, 32'h1000}, {12'h01c, 32'h1000}, {12'h020, 32'h1050},
        {12'h024, 32'h1028}, {12'h014, 32'hfffffffe}, {12'h004, 32'h01000000}, {12'h010, 32'hffffffff},
        {12'h000, 32'h03fffe0f}};

    pes_sampling #(.CW(32)) pes_sampling_inst (.pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .uop, .arch, .init_req, .smm_entry,
        .machine_check, .mem_wr, .mem_ready, .replay_tag_out, .count_pulse, .buf_irq);
    pes_mem_model pes_mem_model_inst (.pclk, .presetn, .stall, .mem_wr, .mem_ready);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One bus transfer; answer and read data are taken at the edge that sees pready high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        err = pslverr;
        q = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // Retires one uop and counts the pulses that follow it.
    task ev(input logic [5:0] cls, input logic t, input logic kl, input logic ts);
        uop <= '{1'h1, t, kl, ts, 16'h0001, cls, 4'h0, 1'h0};
        @(posedge pclk);
        uop.valid <= 1'h0;
        c = 0;
        repeat (3) begin
            @(posedge pclk);
            c += (count_pulse === 1'h1);
        end
    endtask
    // Waits for the memory to hold the given number of words.
    task wait_rec(input int want);
        int n;
        n = 0;
        while (pes_mem_model_inst.n_words != want && n < 60) begin
            n++;
            @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
        chk(32'(pes_mem_model_inst.n_words), 32'(want));
    endtask

    // Clock and watchdog.
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out;
    end

    // Main sequence: table rows, then qualification and sampling cases.
    initial begin
        {psel, penable, pwrite, init_req, smm_entry, machine_check, stall} = '0;
        paddr = '0;
        pwdata = '0;
        uop = '0;
        for (k = 0; k < 10; k++) arch[k*32 +: 32] = 32'h1 << k;
        presetn = 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (i = 0; i < 5; i++) begin
            if (rows[i].wr) apb(1'h1, rows[i].a, rows[i].d);
            apb(1'h0, rows[i].a, 32'h0);
            chk(q & rows[i].m, rows[i].e);
            chk({31'h0, err}, {31'h0, rows[i].err});
        end
        for (i = 0; i < 128; i++) begin
            qq = i[5:2];
            apb(1'h1, 12'h000, {7'h0c, 16'hffff, 5'h00, qq});
            ev(6'h0c, i[0], i[1], i[6]);
            e1 = i[6] ? qq[{~i[0], i[1]}] : (i[1] ? qq[1] | qq[3] : qq[0] | qq[2]);
            chk(32'(c), {31'h0, e1});
        end
        for (i = 0; i < 8; i++) apb(1'h1, setup[i][43:32], setup[i][31:0]);
        ev(6'h01, 1'h0, 1'h0, 1'h1);
        wait_rec(0);
        apb(1'h1, 12'h000, 32'h19fffe0f);
        stall <= 1'h1;
        ev(6'h0c, 1'h0, 1'h0, 1'h1);
        wait_rec(10);
        x = 32'h0;
        for (k = 0; k < 10; k++) x ^= pes_mem_model_inst.mem[32'h1000 + 4 * k];
        chk(x, 32'h3ff);
        chk({31'h0, buf_irq}, 32'h1);
        apb(1'h0, 12'h01c, 32'h0);
        chk(q, 32'h1028);
        apb(1'h0, 12'h010, 32'h0);
        chk(q, 32'hfffffffe);
        stall <= 1'h0;
        ev(6'h0c, 1'h0, 1'h0, 1'h1);
        ev(6'h0c, 1'h0, 1'h0, 1'h1);
        wait_rec(20);
        ev(6'h0c, 1'h0, 1'h0, 1'h1);
        ev(6'h0c, 1'h0, 1'h0, 1'h1);
        wait_rec(20);
        apb(1'h1, 12'h01c, 32'h1000);
        apb(1'h1, 12'h004, 32'h0);
        ev(6'h0c, 1'h0, 1'h0, 1'h1);
        ev(6'h0c, 1'h0, 1'h0, 1'h1);
        wait_rec(20);
        for (k = 0; k < 3; k++) begin
            apb(1'h1, 12'h004, 32'h01000000);
            {init_req, machine_check, smm_entry} <= 3'h1 << k;
            @(posedge pclk);
            {init_req, machine_check, smm_entry} <= 3'h0;
            apb(1'h0, 12'h004, 32'h0);
            chk({31'h0, q[24]}, 32'h0);
        end
        apb(1'h0, 12'h000, 32'h0);
        chk(q, 32'h0);
        // Replay tagging: uop type chosen first, then enable bit 24, bit 25 alone, and neither.
        apb(1'h1, 12'h008, 32'h1);
        apb(1'h1, 12'h000, 32'h30);
        for (k = 0; k < 3; k++) begin
            apb(1'h1, 12'h004, 32'h01000000 << k);
            uop <= '{1'h1, 1'h0, 1'h0, 1'h1, 16'h0, 6'h00, 4'h1, 1'h1};
            @(posedge pclk);
            uop.valid <= 1'h0;
            @(posedge pclk);
            chk({31'h0, replay_tag_out}, {31'h0, k != 1});
        end
        close_out;
    end
endmodule // pes_sampling_test
`default_nettype wire
